// [eep_slave.sv]
// Two-wire target engine of the serial byte EEPROM
`timescale 1ns/1ps

module eep_slave
  import eep_pkg::*;
#(
  parameter logic [2:0] DEV_SELECT   = SELECT_DFLT,
  parameter int         WRITE_CYCLES = WRITE_CYCLES_DFLT
)
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic scl_clk,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  output logic      write_busy
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [12:0] next_in_array(input logic [12:0] a);
    next_in_array = a + ADDR_ONE;
  endfunction

  function automatic logic [12:0] next_in_page(input logic [12:0] a);
    logic [4:0] off;
    off          = a[4:0] + OFF_ONE;
    next_in_page = {a[12:5], off};
  endfunction

  localparam logic [23:0] WCNT_LAST = 24'(WRITE_CYCLES - 1);

  eep_regs_t  r;
  eep_regs_t  next_r;
  logic       link_bit;
  logic [7:0] rd_data;
  logic       rise;
  logic       fall;
  logic       start_ev;
  logic       stop_ev;
  logic [7:0] rx_byte;

  // ------------------------------------------------------------------
  // Link-side capture
  // ------------------------------------------------------------------
  // Data is taken on the controller's own clock edge; the engine reads
  // it only after the resynchronised rise, when it has long settled.
  always_ff @(posedge scl_clk)
  begin
    link_bit <= sda_i;
  end

  // ------------------------------------------------------------------
  // Array
  // ------------------------------------------------------------------
  eep_mem #(
    .AW (ADDR_W),
    .DW (DATA_W)
  ) u_mem (
    .clk   (clk),
    .we    (r.mem_we),
    .waddr (r.mem_waddr),
    .wdata (r.mem_wdata),
    .raddr (r.addr),
    .rdata (rd_data)
  );

  // ------------------------------------------------------------------
  // Engine
  // ------------------------------------------------------------------
  always_comb
  begin
    next_r        = r;
    next_r.mem_we = 1'b0;
    next_r.sda_o  = 1'b0;

    next_r.scl_s1 = scl_clk;
    next_r.scl_s2 = r.scl_s1;
    next_r.scl_s3 = r.scl_s2;
    next_r.sda_s1 = sda_i;
    next_r.sda_s2 = r.sda_s1;
    next_r.sda_s3 = r.sda_s2;
    next_r.lb1    = link_bit;
    next_r.lb2    = r.lb1;

    rise     = r.scl_s2 & ~r.scl_s3;
    fall     = ~r.scl_s2 & r.scl_s3;
    start_ev = r.scl_s2 & r.scl_s3 & r.sda_s3 & ~r.sda_s2;
    stop_ev  = r.scl_s2 & r.scl_s3 & ~r.sda_s3 & r.sda_s2;
    rx_byte  = {r.sh[6:0], r.lb2};

    next_r.rise_d = rise;

    // Timed programming cycle; the page drains in the first 32 clocks
    if (r.busy)
    begin
      if (r.cidx < CIDX_END)
      begin
        next_r.mem_we    = r.valid[r.cidx[4:0]];
        next_r.mem_waddr = {r.addr[12:5], r.cidx[4:0]};
        next_r.mem_wdata = r.pbuf[r.cidx[4:0]];
        next_r.cidx      = r.cidx + CIDX_ONE;
      end
      else
      begin
        next_r.valid = '0;
      end
      next_r.wcnt = r.wcnt + WCNT_ONE;
      if (r.wcnt == WCNT_LAST)
      begin
        next_r.busy = 1'b0;
      end
    end

    if (start_ev)
    begin
      // Also serves repeated START; unfinished data is dropped
      next_r.st       = ST_RX;
      next_r.bit_cnt  = '0;
      next_r.byte_idx = IDX_DEV;
      next_r.sda_oe   = 1'b0;
      if (!r.busy)
      begin
        next_r.valid = '0;
      end
    end
    else if (stop_ev)
    begin
      next_r.st     = ST_IDLE;
      next_r.sda_oe = 1'b0;
      if (!r.busy && (r.valid != '0))
      begin
        next_r.busy = 1'b1;
        next_r.wcnt = '0;
        next_r.cidx = '0;
      end
    end
    else
    begin
      unique case (r.st)
        ST_IDLE:
        begin
          next_r.sda_oe = 1'b0;
        end

        ST_RX:
        begin
          if (r.rise_d && (r.bit_cnt < BITS_PER_BYTE))
          begin
            next_r.sh      = rx_byte;
            next_r.bit_cnt = r.bit_cnt + BIT_ONE;
            if (r.bit_cnt == LAST_BIT)
            begin
              next_r.ack_ok = 1'b1;
              unique case (r.byte_idx)
                IDX_DEV:
                begin
                  next_r.ack_ok   = (rx_byte[7:4] == CLASS_PREFIX)
                                    && (rx_byte[3:1] == DEV_SELECT)
                                    && !r.busy;
                  next_r.rw       = rx_byte[0];
                  next_r.byte_idx = IDX_HI;
                end
                IDX_HI:
                begin
                  next_r.addr_hi  = rx_byte[4:0];
                  next_r.byte_idx = IDX_LO;
                end
                IDX_LO:
                begin
                  next_r.addr     = {r.addr_hi, rx_byte};
                  next_r.byte_idx = IDX_DATA;
                end
                IDX_DATA:
                begin
                  next_r.pbuf[r.addr[4:0]]  = rx_byte;
                  next_r.valid[r.addr[4:0]] = 1'b1;
                  next_r.addr               = next_in_page(r.addr);
                end
              endcase
            end
          end
          else if (fall && (r.bit_cnt == BITS_PER_BYTE))
          begin
            if (r.ack_ok)
            begin
              next_r.st     = ST_RXACK;
              next_r.sda_oe = 1'b1;
            end
            else
            begin
              next_r.st = ST_IDLE;
            end
          end
        end

        ST_RXACK:
        begin
          if (fall)
          begin
            if (r.rw && (r.byte_idx == IDX_HI))
            begin
              next_r.st      = ST_TX;
              next_r.sh      = rd_data;
              next_r.sda_oe  = ~rd_data[7];
              next_r.bit_cnt = BIT_ONE;
            end
            else
            begin
              next_r.st      = ST_RX;
              next_r.sda_oe  = 1'b0;
              next_r.bit_cnt = '0;
            end
          end
        end

        ST_TX:
        begin
          if (fall)
          begin
            if (r.bit_cnt == BITS_PER_BYTE)
            begin
              next_r.st     = ST_TXACK;
              next_r.sda_oe = 1'b0;
              next_r.addr   = next_in_array(r.addr);
            end
            else
            begin
              next_r.sh      = {r.sh[6:0], 1'b0};
              next_r.sda_oe  = ~r.sh[6];
              next_r.bit_cnt = r.bit_cnt + BIT_ONE;
            end
          end
        end

        ST_TXACK:
        begin
          if (r.rise_d)
          begin
            next_r.mack = ~r.lb2;
          end
          else if (fall)
          begin
            if (r.mack)
            begin
              next_r.st      = ST_TX;
              next_r.sh      = rd_data;
              next_r.sda_oe  = ~rd_data[7];
              next_r.bit_cnt = BIT_ONE;
            end
            else
            begin
              next_r.st = ST_IDLE;
            end
          end
        end

        default:
        begin
          next_r.st     = ST_IDLE;
          next_r.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Reset stands for the power-on detector; the array is not touched
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r        <= '0;
      r.st     <= ST_IDLE;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_s3 <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_s3 <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign sda_o      = r.sda_o;
  assign sda_oe     = r.sda_oe;
  assign write_busy = r.busy;

endmodule

// [eep_mem.sv]
// Shared constants and the byte array that holds the stored data
`timescale 1ns/1ps

package eep_pkg;

  // ------------------------------------------------------------------
  // Array and page geometry
  // ------------------------------------------------------------------
  localparam int             ADDR_W        = 13;
  localparam int             DATA_W        = 8;
  localparam int             OFF_W         = 5;
  localparam int             PAGE_BYTES    = 32;
  localparam logic [7:0]     ERASED_BYTE   = 8'hFF;
  localparam logic [12:0]    ADDR_ONE      = 13'h0001;
  localparam logic [4:0]     OFF_ONE       = 5'h01;

  // ------------------------------------------------------------------
  // Bus protocol constants
  // ------------------------------------------------------------------
  localparam logic [3:0]     CLASS_PREFIX  = 4'hA;
  localparam logic [2:0]     SELECT_DFLT   = 3'h0;
  localparam logic [3:0]     BIT_ONE       = 4'h1;
  localparam logic [3:0]     LAST_BIT      = 4'h7;
  localparam logic [3:0]     BITS_PER_BYTE = 4'h8;
  localparam logic [1:0]     IDX_DEV       = 2'h0;
  localparam logic [1:0]     IDX_HI        = 2'h1;
  localparam logic [1:0]     IDX_LO        = 2'h2;
  localparam logic [1:0]     IDX_DATA      = 2'h3;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int             CLK_HZ              = 50_000_000;
  localparam int             MS_PER_S            = 1000;
  localparam int             WRITE_CYCLE_TIME_MS = 4;
  localparam int             WRITE_CYCLES_DFLT   = WRITE_CYCLE_TIME_MS * (CLK_HZ / MS_PER_S);
  localparam int             WCNT_W              = 24;
  localparam logic [23:0]    WCNT_ONE            = 24'h000001;
  localparam logic [5:0]     CIDX_ONE            = 6'h01;
  localparam logic [5:0]     CIDX_END            = 6'h20;

  // ------------------------------------------------------------------
  // Engine state
  // ------------------------------------------------------------------
  typedef enum logic [4:0]
  {
    ST_IDLE  = 5'h01,
    ST_RX    = 5'h02,
    ST_RXACK = 5'h04,
    ST_TX    = 5'h08,
    ST_TXACK = 5'h10
  } eep_state_t;

  typedef struct packed
  {
    eep_state_t        st;
    logic [3:0]        bit_cnt;
    logic [1:0]        byte_idx;
    logic              rw;
    logic              ack_ok;
    logic              mack;
    logic [7:0]        sh;
    logic [12:0]       addr;
    logic [4:0]        addr_hi;
    logic [31:0][7:0]  pbuf;
    logic [31:0]       valid;
    logic              busy;
    logic [23:0]       wcnt;
    logic [5:0]        cidx;
    logic              scl_s1;
    logic              scl_s2;
    logic              scl_s3;
    logic              sda_s1;
    logic              sda_s2;
    logic              sda_s3;
    logic              lb1;
    logic              lb2;
    logic              rise_d;
    logic              sda_o;
    logic              sda_oe;
    logic              mem_we;
    logic [12:0]       mem_waddr;
    logic [7:0]        mem_wdata;
  } eep_regs_t;

endpackage

module eep_mem
  import eep_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)
(
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  // Delivered erased; contents survive reset like the real cells
  logic [DW-1:0] mem [2**AW] = '{default: ERASED_BYTE};

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// [eep_ctl_model.sv]
// Bus controller model that drives the serial clock and pulls the data line
`timescale 1ns/1ps

module eep_ctl_model
(
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  logic tk = 1'b0;
  int   half = 3;

  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end

  // Odd offset keeps link edges off the system clock edges
  initial #7 forever #24 tk = ~tk;

  task automatic w();
    repeat (half) @(posedge tk);
  endtask

  task automatic start();
    if (scl == 1'b0)
    begin
      pull = 1'b0;
      w();
      scl = 1'b1;
      w();
    end
    pull = 1'b1;
    w();
    scl = 1'b0;
    w();
  endtask

  // Data changes only while the clock is low
  task automatic bt(input logic b, output logic r);
    pull = ~b;
    w();
    scl = 1'b1;
    w();
    r = sda;
    scl = 1'b0;
    w();
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bt(d[i], r);
    bt(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bt(1'b1, r);
      d[i] = r;
    end
    bt(~more, r);
  endtask

  task automatic stop();
    pull = 1'b1;
    w();
    scl = 1'b1;
    w();
    pull = 1'b0;
    w();
  endtask
endmodule

// [eep_slave_assertions.sv]
// Protocol assertions for the serial EEPROM target engine
`timescale 1ns/1ps

module eep_slave_assertions
  import eep_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_clk,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic write_busy
);
  int   busy_cnt;
  int   low_cnt;
  int   stop_age;
  logic in_frame;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Pins are sampled raw, so they lead the engine's synchroniser
  always_ff @(posedge clk)
  begin
    busy_cnt <= write_busy ? busy_cnt + 1 : 0;
    low_cnt  <= scl_clk ? 0 : low_cnt + 1;
    stop_age <= (scl_clk && $rose(sda_i)) ? 0 : stop_age + 1;
    if (scl_clk && $fell(sda_i))
      in_frame <= 1'b1;
    else if (scl_clk && $rose(sda_i))
      in_frame <= 1'b0;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_busy_on;
    $rose(write_busy);
  endsequence
  sequence s_stop_recent;
    stop_age inside {[1:6]};
  endsequence

  property p_open_drain;
    sda_oe |-> !sda_o;
  endproperty
  property p_reset_quiet;
    $fell(reset) |-> !sda_oe && !write_busy;
  endproperty
  property p_change_low;
    $changed(sda_oe) |-> !scl_clk && low_cnt inside {[2:6]};
  endproperty
  property p_frame;
    $rose(sda_oe) |-> in_frame;
  endproperty
  property p_standby;
    !in_frame |-> !sda_oe;
  endproperty
  property p_busy_silent;
    write_busy |-> !sda_oe;
  endproperty
  property p_busy_len;
    $fell(write_busy) |-> busy_cnt == WRITE_CYCLES;
  endproperty
  property p_busy_start;
    s_busy_on |-> s_stop_recent ##1 write_busy [*8];
  endproperty

  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  a_change_low: assert property (p_change_low)
    else $error("data drive changed outside clock low");
  a_frame: assert property (p_frame)
    else $error("drive without start");
  a_standby: assert property (p_standby)
    else $error("drive outside a transaction");
  a_busy_silent: assert property (p_busy_silent)
    else $error("acknowledge during programming");
  a_busy_len: assert property (p_busy_len)
    else $error("programming length wrong");
  a_busy_start: assert property (p_busy_start)
    else $error("programming not launched by stop");
endmodule

bind eep_slave eep_slave_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk
(
  .clk        (clk),
  .reset      (reset),
  .scl_clk    (scl_clk),
  .sda_i      (sda_i),
  .sda_o      (sda_o),
  .sda_oe     (sda_oe),
  .write_busy (write_busy)
);

// [tb_top.sv]
// Self-checking bench for the serial EEPROM target engine
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("[ERR] %s exp %h got %h", nm, exp, got); \
    end \
  end

module tb_top
  import eep_pkg::*;
;
  // Long enough that the first poll is refused
  localparam int         WCYC = 300;
  localparam logic [6:0] DEV  = {CLASS_PREFIX, SELECT_DFLT};

  typedef struct packed
  {
    logic [15:0] a;
    logic [15:0] r;
    logic [7:0]  d;
    logic [7:0]  n;
  } eep_row_t;

  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       scl;
  logic       pull;
  logic       sda_i;
  logic       sda_o;
  logic       sda_oe;
  logic       write_busy;
  logic       k;
  logic [7:0] rd;
  logic [7:0] pg [$];
  int         mismatches = 0;
  int         compares = 0;
  eep_row_t   rows [3] = '{
    '{16'h0010, 16'h0010, 8'hA5, 8'hFF},
    '{16'hE123, 16'h0123, 8'h3C, 8'hFF},
    '{16'h1FFF, 16'h1FFF, 8'h5A, 8'hFF}
  };

  always #10 clk = ~clk;
  assign sda_i = ~(sda_oe | pull);

  eep_slave
  #(
    .DEV_SELECT   (SELECT_DFLT),
    .WRITE_CYCLES (WCYC)
  )
  dut
  (
    .clk        (clk),
    .reset      (reset),
    .scl_clk    (scl),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe     (sda_oe),
    .write_busy (write_busy)
  );

  eep_ctl_model ctl
  (
    .sda  (sda_i),
    .scl  (scl),
    .pull (pull)
  );

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic set_addr(input logic [15:0] a);
    ctl.start();
    ctl.wbyte({DEV, 1'b0}, k);
    `CHK("dev ack", 1'b1, k)
    ctl.wbyte(a[15:8], k);
    `CHK("hi ack", 1'b1, k)
    ctl.wbyte(a[7:0], k);
    `CHK("lo ack", 1'b1, k)
  endtask

  // Select-only probes also prove that no data means no programming
  task automatic poll();
    int n;
    n = 0;
    k = 1'b0;
    while (!k && n < 20)
    begin
      ctl.start();
      ctl.wbyte({DEV, 1'b0}, k);
      ctl.stop();
      n++;
    end
    `CHK("refused", 1'b1, n > 1)
    `CHK("poll ack", 1'b1, k)
    repeat (10) @(negedge clk);
    `CHK("idle busy", 1'b0, write_busy)
  endtask

  task automatic write_at(input logic [15:0] a, input logic [7:0] d [$]);
    set_addr(a);
    foreach (d[i])
    begin
      ctl.wbyte(d[i], k);
      `CHK("data ack", 1'b1, k)
    end
    ctl.stop();
    `CHK("busy on", 1'b1, write_busy)
    poll();
  endtask

  task automatic read_at(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    set_addr(a);
    ctl.start();
    ctl.wbyte({DEV, 1'b1}, k);
    `CHK("read ack", 1'b1, k)
    ctl.rbyte(1'b1, rd);
    `CHK("rd0", e0, rd)
    ctl.rbyte(1'b0, rd);
    `CHK("rd1", e1, rd)
    ctl.stop();
  endtask

  initial
  begin
    #1500000;
    mismatches++;
    report_and_stop();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    foreach (rows[i])
    begin
      write_at(rows[i].a, {rows[i].d});
      read_at(rows[i].r, rows[i].d, rows[i].n);
      $display("row %0d done", i);
    end
    read_at(16'h0400, 8'hFF, 8'hFF);
    ctl.start();
    ctl.wbyte({CLASS_PREFIX, 3'h4, 1'b0}, k);
    ctl.stop();
    `CHK("other select", 1'b0, k)
    $display("fresh and select done");
    for (int i = 0; i < 33; i++)
      pg.push_back(8'(i));
    write_at(16'h0080, pg);
    ctl.start();
    ctl.wbyte({DEV, 1'b1}, k);
    ctl.rbyte(1'b0, rd);
    ctl.stop();
    `CHK("current addr", 8'h01, rd)
    read_at(16'h0080, 8'h20, 8'h01);
    read_at(16'h009F, 8'h1F, 8'hFF);
    $display("page wrap done");
    set_addr(16'h0010);
    ctl.stop();
    repeat (10) @(negedge clk);
    `CHK("no data busy", 1'b0, write_busy)
    ctl.half = 6;
    read_at(16'h0010, 8'hA5, 8'hFF);
    ctl.half = 3;
    $display("empty write done");
    reset = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("reset oe", 1'b0, sda_oe)
    `CHK("reset o", 1'b0, sda_o)
    `CHK("reset busy", 1'b0, write_busy)
    reset = 1'b0;
    repeat (4) @(negedge clk);
    read_at(16'h0123, 8'h3C, 8'hFF);
    $display("second reset done");
    report_and_stop();
  end
endmodule
